/* File: src/stc_edge_sync.sv */
// External clock pin synchroniser and rising-edge detector
`timescale 1ns/10ps
module stc_edge_sync
    import stc_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic pin,
    input  wire logic bypass,
    output wire logic rise
);
    logic stage1;    // First sync flop, read only by stage2
    logic stage2;    // Synchronised level
    logic prev_sync; // Last synchronised level
    logic prev_raw;  // Last raw level for bypass path

    // Two-flop synchroniser plus edge history
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            stage1    <= 1'b0;
            stage2    <= 1'b0;
            prev_sync <= 1'b0;
            prev_raw  <= 1'b0;
        end
        else
        begin
            stage1    <= pin;
            stage2    <= stage1;
            prev_sync <= stage2;
            prev_raw  <= pin;
        end
    end

    assign rise = bypass ? (pin & ~prev_raw) : (stage2 & ~prev_sync);

    sync_path_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!bypass && rise) |-> ($past(pin, 2) && !$past(pin, 3)))
        else $error("synchronised edge not two cycles after pin rise");

endmodule // stc_edge_sync

/* File: src/stc_pkg.sv */
// Shared constants and types for the sixteen-bit timer/counter
package stc_pkg;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam int          STC_ADDR_W    = 8;
    localparam logic [7:0]  STC_OFF_CTRL  = 8'h00;  // timer_control_reg
    localparam logic [7:0]  STC_OFF_LOW   = 8'h04;  // count_low_byte
    localparam logic [7:0]  STC_OFF_HIGH  = 8'h08;  // count_high_byte
    localparam logic [7:0]  STC_OFF_STAT  = 8'h0C;  // Sticky event status
    localparam logic [7:0]  STC_OFF_CLR   = 8'h10;  // Write-one-to-clear
    localparam logic [7:0]  STC_OFF_IEN   = 8'h14;  // Interrupt enable

    // ----------------------------------------
    // Control field positions and reset values
    // ----------------------------------------
    localparam int          STC_BIT_RUN   = 0;
    localparam int          STC_BIT_SRC   = 1;
    localparam int          STC_BIT_BYP   = 2;
    localparam int          STC_BIT_OSC   = 3;
    localparam int          STC_BIT_PSLO  = 4;
    localparam int          STC_BIT_PSHI  = 5;
    localparam int          STC_BIT_SYSCK = 6;
    localparam int          STC_BIT_WIDE  = 7;
    localparam logic [7:0]  STC_CTRL_RST  = 8'h00;
    localparam logic [7:0]  STC_CTRL_WMSK = 8'hBF;  // Bit 6 is read-only
    localparam logic [15:0] STC_COUNT_RST = 16'h0000;
    localparam logic [15:0] STC_COUNT_MAX = 16'hFFFF;
    localparam int          STC_PS_W      = 3;      // Prescale counter width
    localparam int          STC_IRQ_OVF   = 0;      // Overflow status bit

    // ----------------------------------------
    // Bus responses and channel states
    // ----------------------------------------
    localparam logic [1:0]  STC_RESP_OKAY = 2'h0;
    localparam logic [1:0]  STC_RESP_ERR  = 2'h2;

    typedef enum logic [1:0] {STC_WR_IDLE = 2'b01, STC_WR_RESP = 2'b10} stc_wr_state_type;
    typedef enum logic [1:0] {STC_RD_IDLE = 2'b01, STC_RD_DATA = 2'b10} stc_rd_state_type;

endpackage

/* File: src/stc_prescaler.sv */
// Input clock prescaler with 1, 2, 4 or 8 division
`timescale 1ns/10ps
module stc_prescaler
    import stc_pkg::*;
#(
    parameter int PS_W = STC_PS_W
)
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       tick_in,
    input  wire logic       clear,
    input  wire logic [1:0] select,
    output wire logic       tick_out
);
    logic [PS_W-1:0] div_count; // Input ticks seen
    wire  [PS_W-1:0] div_mask;  // Terminal pattern for this ratio

    assign div_mask = PS_W'((1 << select) - 1);
    assign tick_out = tick_in && ((div_count & div_mask) == div_mask);

    // Divider counter, cleared by low byte writes
    always_ff @(posedge aclk)
    begin
        if (!aresetn || clear)
            div_count <= '0;
        else if (tick_in)
            div_count <= PS_W'(div_count + 1'b1);
    end

    prescale_gap_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (select == 2'b11 && tick_out) |=> (!tick_out || select != 2'b11) [*7])
        else $error("divide by eight ticked early");

endmodule // stc_prescaler

/* File: src/stc_timer_top.sv */
// Sixteen-bit timer/counter with AXI4-Lite register slave
`timescale 1ns/10ps
module stc_timer_top
    import stc_pkg::*;
(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [STC_ADDR_W-1:0] awaddr,
    input  wire logic [2:0]            awprot,
    input  wire logic                  awvalid,
    output wire logic                  awready,
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output wire logic                  wready,
    output logic      [1:0]            bresp,
    output wire logic                  bvalid,
    input  wire logic                  bready,
    input  wire logic [STC_ADDR_W-1:0] araddr,
    input  wire logic [2:0]            arprot,
    input  wire logic                  arvalid,
    output wire logic                  arready,
    output logic      [31:0]           rdata,
    output logic      [1:0]            rresp,
    output wire logic                  rvalid,
    input  wire logic                  rready,
    input  wire logic                  ext_clock_pin,
    input  wire logic                  special_event_trigger,
    input  wire logic                  sysclk_from_timer_osc,
    output wire logic                  timer_osc_enable,
    output wire logic                  irq
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    stc_wr_state_type        wr_state;    // Write channel state
    stc_rd_state_type        rd_state;    // Read channel state
    logic                    aw_held;     // Write address captured
    logic                    w_held;      // Write data captured
    logic [STC_ADDR_W-1:0]   aw_addr_q;   // Captured write address
    logic [7:0]              w_data_q;    // Captured low data byte
    logic                    w_lane0_q;   // Captured strobe for byte 0
    logic [7:0]              ctrl_q;      // timer_control_reg store
    logic [15:0]             count;       // The counter itself
    logic [15:0]             next_count;  // Counter next value
    logic [7:0]              high_buffer; // Wide-mode high byte buffer
    logic [0:0]              irq_status;  // Sticky events
    logic [0:0]              irq_enable;  // Interrupt enables
    logic                    ovf_event;   // Wrap this cycle

    // ----------------------------------------
    // Control fields
    // ----------------------------------------
    wire       count_run_enable      = ctrl_q[STC_BIT_RUN];
    wire       clock_source_select   = ctrl_q[STC_BIT_SRC];
    wire       ext_clock_sync_bypass = ctrl_q[STC_BIT_BYP];
    wire [1:0] prescale_select       = ctrl_q[STC_BIT_PSHI:STC_BIT_PSLO];
    wire       wide_access_enable    = ctrl_q[STC_BIT_WIDE];

    assign timer_osc_enable = ctrl_q[STC_BIT_OSC];

    // ----------------------------------------
    // Write channel handshake
    // ----------------------------------------
    assign awready  = !aw_held && (wr_state == STC_WR_IDLE);
    assign wready   = !w_held && (wr_state == STC_WR_IDLE);
    assign bvalid   = (wr_state == STC_WR_RESP);
    wire   do_write = (wr_state == STC_WR_IDLE) && aw_held && w_held;
    wire   wr_en    = do_write && w_lane0_q;

    // Write address decode
    wire wr_ctrl  = wr_en && (aw_addr_q == STC_OFF_CTRL);
    wire wr_low   = wr_en && (aw_addr_q == STC_OFF_LOW);
    wire wr_high  = wr_en && (aw_addr_q == STC_OFF_HIGH);
    wire wr_clr   = wr_en && (aw_addr_q == STC_OFF_CLR);
    wire wr_ien   = wr_en && (aw_addr_q == STC_OFF_IEN);
    wire wr_known = (aw_addr_q == STC_OFF_CTRL) || (aw_addr_q == STC_OFF_LOW)
                 || (aw_addr_q == STC_OFF_HIGH) || (aw_addr_q == STC_OFF_STAT)
                 || (aw_addr_q == STC_OFF_CLR)  || (aw_addr_q == STC_OFF_IEN);

    // Capture write address and data in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held   <= 1'b0;
            w_held    <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= 8'h00;
            w_lane0_q <= 1'b0;
        end
        else
        begin
            // Address channel
            if (awvalid && awready)
            begin
                aw_held   <= 1'b1;
                aw_addr_q <= awaddr;
            end
            else if (do_write)
                aw_held <= 1'b0;
            // Data channel
            if (wvalid && wready)
            begin
                w_held    <= 1'b1;
                w_data_q  <= wdata[7:0];
                w_lane0_q <= wstrb[0];
            end
            else if (do_write)
                w_held <= 1'b0;
        end
    end

    // Write response state machine
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_state <= STC_WR_IDLE;
            bresp    <= STC_RESP_OKAY;
        end
        else
        begin
            case (wr_state)
                STC_WR_IDLE:
                    if (do_write)
                    begin
                        wr_state <= STC_WR_RESP;
                        bresp    <= wr_known ? STC_RESP_OKAY : STC_RESP_ERR;
                    end
                STC_WR_RESP:
                    if (bready)
                        wr_state <= STC_WR_IDLE;
                default:
                    wr_state <= STC_WR_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Read channel
    // ----------------------------------------
    assign arready = (rd_state == STC_RD_IDLE);
    assign rvalid  = (rd_state == STC_RD_DATA);
    wire   rd_take = arvalid && arready;
    wire   rd_low  = rd_take && (araddr == STC_OFF_LOW);

    // live oscillator status in bit 6
    wire [7:0] ctrl_view = {ctrl_q[STC_BIT_WIDE], sysclk_from_timer_osc,
                            ctrl_q[STC_BIT_SYSCK-1:0]};
    // high byte through buffer in wide mode
    wire [7:0] high_view = wide_access_enable ? high_buffer : count[15:8];

    // Read data selection
    wire [7:0] rd_byte =
        (araddr == STC_OFF_CTRL) ? ctrl_view :
        (araddr == STC_OFF_LOW)  ? count[7:0] :
        (araddr == STC_OFF_HIGH) ? high_view :
        (araddr == STC_OFF_STAT) ? {7'h00, irq_status} :
        (araddr == STC_OFF_IEN)  ? {7'h00, irq_enable} : 8'h00;
    wire rd_known = (araddr == STC_OFF_CTRL) || (araddr == STC_OFF_LOW)
                 || (araddr == STC_OFF_HIGH) || (araddr == STC_OFF_STAT)
                 || (araddr == STC_OFF_CLR)  || (araddr == STC_OFF_IEN);

    // Read state machine with registered data
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rd_state <= STC_RD_IDLE;
            rdata    <= 32'h0000_0000;
            rresp    <= STC_RESP_OKAY;
        end
        else
        begin
            case (rd_state)
                STC_RD_IDLE:
                    if (rd_take)
                    begin
                        rd_state <= STC_RD_DATA;
                        rdata    <= {24'h00_0000, rd_byte};
                        rresp    <= rd_known ? STC_RESP_OKAY : STC_RESP_ERR;
                    end
                STC_RD_DATA:
                    if (rready)
                        rd_state <= STC_RD_IDLE;
                default:
                    rd_state <= STC_RD_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ctrl_q <= STC_CTRL_RST;
        else if (wr_ctrl)
            ctrl_q <= w_data_q & STC_CTRL_WMSK;
    end

    // ----------------------------------------
    // Clock source and prescaler
    // ----------------------------------------
    wire ext_rise;   // Qualified external edge
    wire count_tick; // Prescaled count advance

    // External pin edge detection
    stc_edge_sync u_edge_sync (
        .aclk   (aclk),
        .aresetn(aresetn),
        .pin    (ext_clock_pin),
        .bypass (ext_clock_sync_bypass),
        .rise   (ext_rise)
    );

    wire src_tick = count_run_enable && (clock_source_select ? ext_rise : 1'b1);

    // Division ahead of the counter
    stc_prescaler #(.PS_W(STC_PS_W)) u_prescaler (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick_in (src_tick),
        .clear   (wr_low),
        .select  (prescale_select),
        .tick_out(count_tick)
    );

    // ----------------------------------------
    // Counter update
    // ----------------------------------------
    always_comb
    begin
        next_count = count;
        ovf_event  = 1'b0;
        // low write commits buffered high byte in wide mode, keeps count high byte in byte mode
        if (wr_low)
            next_count = {high_view, w_data_q};
        // direct high byte write in byte mode
        else if (wr_high && !wide_access_enable)
            next_count = {w_data_q, count[7:0]};
        else if (special_event_trigger)
            next_count = STC_COUNT_RST;
        // wrap from all ones to zero
        else if (count_tick)
        begin
            next_count = 16'(count + 16'h0001);
            ovf_event  = (count == STC_COUNT_MAX);
        end
    end

    // Count and high byte buffer registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            count       <= STC_COUNT_RST;
            high_buffer <= 8'h00;
        end
        else
        begin
            count <= next_count;
            // buffer loads on high write or low read, in wide mode only
            if (wr_high && wide_access_enable)
                high_buffer <= w_data_q;
            else if (rd_low && wide_access_enable)
                high_buffer <= count[15:8];
        end
    end

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    wire [0:0] clr_mask = wr_clr ? w_data_q[0:0] : 1'b0;

    // sticky flag, a new event beats the clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_status <= 1'b0;
            irq_enable <= 1'b0;
        end
        else
        begin
            irq_status <= (irq_status & ~clr_mask) | ovf_event;
            if (wr_ien)
                irq_enable <= w_data_q[0:0];
        end
    end

    // Level interrupt from enabled status
    assign irq = |(irq_status & irq_enable);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Quiet cycle: no low write, no byte-mode high write and no trigger
    wire quiet = !wr_low && !(wr_high && !wide_access_enable) && !special_event_trigger;

    sequence wide_low_write_s;
        wr_low && wide_access_enable;
    endsequence

    sequence wrap_s;
        quiet && count_tick && (count == STC_COUNT_MAX);
    endsequence

    halt_hold_a: assert property (
        (!count_run_enable && quiet) |=> (count == $past(count)))
        else $error("count moved while halted");

    ext_source_a: assert property (
        (clock_source_select && !ext_rise && quiet) |=> (count == $past(count)))
        else $error("external mode counted without an edge");

    wrap_flag_a: assert property (
        wrap_s |=> (count == STC_COUNT_RST) && irq_status[STC_IRQ_OVF])
        else $error("overflow did not wrap and flag");

    trig_clear_a: assert property (
        (special_event_trigger && !wr_low && !(wr_high && !wide_access_enable))
        |=> (count == STC_COUNT_RST))
        else $error("trigger did not clear the count");

    wide_write_a: assert property (
        wide_low_write_s |=> (count[15:8] == $past(high_buffer)))
        else $error("wide low write lost buffered high byte");

    status_bit_a: assert property (
        (rd_take && araddr == STC_OFF_CTRL)
        |=> (rdata[STC_BIT_SYSCK] == $past(sysclk_from_timer_osc)))
        else $error("clock status bit misreported");

    osc_enable_a: assert property (
        wr_ctrl |=> (timer_osc_enable == $past(w_data_q[STC_BIT_OSC])))
        else $error("oscillator enable not following write");

endmodule // stc_timer_top

/* File: testbench/stc_ext_clock_model.sv */
// Behavioural model of the external clock pin and the timer oscillator
`timescale 1ns/10ps
module stc_ext_clock_model
(
    input  wire logic aclk,
    input  wire logic timer_osc_enable,
    input  wire logic use_timer_osc,
    output logic      ext_clock_pin,
    output wire logic sysclk_from_timer_osc
);
    // ----------------------------------------
    // Oscillator and system clock status
    // ----------------------------------------
    // oscillator feeds system clock only while running
    assign sysclk_from_timer_osc = use_timer_osc & timer_osc_enable;

    // Pin rests low between bursts
    initial ext_clock_pin = 1'b0;

    // ----------------------------------------
    // Edge bursts on the external pin
    // ----------------------------------------
    // rising edges, each level held for half cycles
    task automatic make_edges(input int n, input int half);
        repeat (n)
        begin
            @(posedge aclk);
            ext_clock_pin <= 1'b1;
            repeat (half) @(posedge aclk);
            ext_clock_pin <= 1'b0;
            repeat (half - 1) @(posedge aclk);
        end
    endtask
endmodule // stc_ext_clock_model

/* File: testbench/test_sixteen_bit_timer_counter.sv */
// Self-checking testbench of the sixteen-bit timer/counter
`timescale 1ns/10ps
module test_sixteen_bit_timer_counter;
    import stc_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, trig, use_osc;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata;
    wire         awready, wready, bvalid, arready, rvalid, irq, osc_en, pin, sysck;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    int          n_errors, tests_run, cyc, last_b;
    logic [31:0] rd;
    logic [3:0]  strb;
    logic [1:0]  rs;

    // Clock of 50 ns period
    initial
    begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    // Cycle stamp for write commit timing
    always @(posedge aclk) cyc <= cyc + 1;

    stc_timer_top dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(strb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .ext_clock_pin(pin), .special_event_trigger(trig),
        .sysclk_from_timer_osc(sysck), .timer_osc_enable(osc_en), .irq(irq));
    stc_ext_clock_model model_u (.aclk(aclk), .timer_osc_enable(osc_en),
        .use_timer_osc(use_osc), .ext_clock_pin(pin), .sysclk_from_timer_osc(sysck));

    // ----------------------------------------
    // Comparison, bus and closing tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Address and data offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic aw, w, ta, tw, tb;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw = 1'b1;
        w = 1'b1;
        while (aw || w)
        begin
            @(negedge aclk);
            ta = aw && (awready === 1'b1);
            tw = w && (wready === 1'b1);
            @(posedge aclk);
            if (ta)
            begin
                awvalid <= 1'b0;
                aw = 1'b0;
            end
            if (tw)
            begin
                wvalid <= 1'b0;
                w = 1'b0;
            end
        end
        tb = 1'b0;
        while (!tb)
        begin
            @(negedge aclk);
            tb = (bvalid === 1'b1);
            rs = bresp;
            @(posedge aclk);
        end
        bready <= 1'b0;
        last_b = cyc;
    endtask

    // Read answer taken at the edge where rvalid is seen
    task automatic rdr(input logic [7:0] a);
        logic ta, tr;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        ta = 1'b0;
        while (!ta)
        begin
            @(negedge aclk);
            ta = (arready === 1'b1);
            @(posedge aclk);
        end
        arvalid <= 1'b0;
        tr = 1'b0;
        while (!tr)
        begin
            @(negedge aclk);
            tr = (rvalid === 1'b1);
            rd = rdata;
            rs = rresp;
            @(posedge aclk);
        end
        rready <= 1'b0;
    endtask

    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        rdr(a);
        chk(what, exp, rd);
    endtask

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset_map;
        rchk("control reset", STC_OFF_CTRL, 32'h0);
        chk("mapped read resp", {30'h0, STC_RESP_OKAY}, {30'h0, rs});
        rchk("low reset", STC_OFF_LOW, 32'h0);
        rchk("high reset", STC_OFF_HIGH, 32'h0);
        rchk("status reset", STC_OFF_STAT, 32'h0);
        rdr(8'h18);
        chk("unmapped read resp", {30'h0, STC_RESP_ERR}, {30'h0, rs});
        wr(8'h18, 8'hFF);
        chk("unmapped write resp", {30'h0, STC_RESP_ERR}, {30'h0, rs});
        // Lane 0 strobe low: answered OKAY, register untouched
        strb <= 4'hE;
        wr(STC_OFF_IEN, 8'h01);
        strb <= 4'hF;
        chk("lane0 off write resp", {30'h0, STC_RESP_OKAY}, {30'h0, rs});
        rchk("lane0 off no effect", STC_OFF_IEN, 32'h0);
        $display("Test reset_map done");
    endtask

    task automatic t_control;
        wr(STC_OFF_CTRL, 8'hFF);
        chk("mapped write resp", {30'h0, STC_RESP_OKAY}, {30'h0, rs});
        rchk("control ro bit", STC_OFF_CTRL, 32'hBF);
        chk("osc enable on", 1, osc_en);
        use_osc <= 1'b1;
        rchk("sysclk status set", STC_OFF_CTRL, 32'hFF);
        wr(STC_OFF_CTRL, 8'h00);
        chk("osc enable off", 0, osc_en);
        rchk("sysclk status off", STC_OFF_CTRL, 32'h00);
        use_osc <= 1'b0;
        $display("Test control done");
    endtask

    task automatic t_prescale;
        int d, div, got, t0;
        for (int ps = 0; ps < 4; ps++)
        begin
            div = 1 << ps;
            wr(STC_OFF_HIGH, 8'h00);
            wr(STC_OFF_LOW, 8'h00);
            wr(STC_OFF_CTRL, 8'(ps << 4) | 8'h01);
            t0 = last_b;
            repeat (64) @(posedge aclk);
            wr(STC_OFF_CTRL, 8'(ps << 4));
            d = last_b - t0;
            rdr(STC_OFF_LOW);
            got = int'(rd[7:0]);
            chk("prescaled count", 1, (got >= (d - 3) / div) && (got <= (d + 2) / div));
            rchk("count held", STC_OFF_LOW, rd);
        end
        $display("Test prescale done");
    endtask

    task automatic t_external;
        wr(STC_OFF_LOW, 8'h00);
        wr(STC_OFF_CTRL, 8'h03);
        model_u.make_edges(5, 4);
        repeat (6) @(posedge aclk);
        rchk("ext sync count", STC_OFF_LOW, 32'h05);
        wr(STC_OFF_CTRL, 8'h07);
        model_u.make_edges(3, 3);
        repeat (6) @(posedge aclk);
        rchk("ext bypass count", STC_OFF_LOW, 32'h08);
        wr(STC_OFF_CTRL, 8'h00);
        $display("Test external done");
    endtask

    task automatic t_wide_trigger;
        wr(STC_OFF_HIGH, 8'h12);
        wr(STC_OFF_LOW, 8'h34);
        rchk("byte low", STC_OFF_LOW, 32'h34);
        rchk("byte high", STC_OFF_HIGH, 32'h12);
        wr(STC_OFF_CTRL, 8'h80);
        wr(STC_OFF_HIGH, 8'hAB);
        rchk("wide low", STC_OFF_LOW, 32'h34);
        rchk("wide high buffer", STC_OFF_HIGH, 32'h12);
        wr(STC_OFF_HIGH, 8'hAB);
        wr(STC_OFF_LOW, 8'hCD);
        rchk("wide load low", STC_OFF_LOW, 32'hCD);
        rchk("wide load high", STC_OFF_HIGH, 32'hAB);
        @(posedge aclk);
        trig <= 1'b1;
        @(posedge aclk);
        trig <= 1'b0;
        rchk("trigger low", STC_OFF_LOW, 32'h00);
        rchk("trigger high", STC_OFF_HIGH, 32'h00);
        wr(STC_OFF_CTRL, 8'h00);
        $display("Test wide_trigger done");
    endtask

    task automatic t_overflow;
        wr(STC_OFF_HIGH, 8'hFF);
        wr(STC_OFF_LOW, 8'hFE);
        wr(STC_OFF_CTRL, 8'h01);
        repeat (20) @(posedge aclk);
        wr(STC_OFF_CTRL, 8'h00);
        rchk("wrapped high", STC_OFF_HIGH, 32'h00);
        rchk("overflow flag", STC_OFF_STAT, 32'h01);
        chk("irq masked", 0, irq);
        wr(STC_OFF_IEN, 8'h01);
        rchk("irq enable readback", STC_OFF_IEN, 32'h01);
        chk("irq raised", 1, irq);
        wr(STC_OFF_IEN, 8'h00);
        chk("irq disabled", 0, irq);
        wr(STC_OFF_IEN, 8'h01);
        wr(STC_OFF_CLR, 8'h01);
        rchk("flag cleared", STC_OFF_STAT, 32'h00);
        chk("irq cleared", 0, irq);
        $display("Test overflow done");
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready, trig, use_osc} = '0;
        {awaddr, araddr, wdata} = '0;
        strb = 4'hF;
        {n_errors, tests_run, cyc, last_b} = '0;
        aresetn = 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset_map();
        t_control();
        t_prescale();
        t_external();
        t_wide_trigger();
        t_overflow();
        finish_test();
    end

    initial
    begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        finish_test();
    end
endmodule // test_sixteen_bit_timer_counter
